// ===== shared/ehiop_defs.svh
// constants of the handler port: timing, register map, fields, reset values
`ifndef EHIOP_DEFS_SVH
`define EHIOP_DEFS_SVH

// timing: clock rate and documented times in microseconds
`define EHIOP_CLK_MHZ 100
`define EHIOP_EXT_START_N_MIN_US 100
`define EHIOP_RESP_US 200

// highest setup number that may be selected
`define EHIOP_MAX_SETUP 7'h63

// drive level tolerance: error beyond one tenth of the set level
`define EHIOP_DRV_TOL_DIV 16'h000a

// register byte offsets
`define EHIOP_A_CTRL 8'h00
`define EHIOP_A_CMD 8'h04
`define EHIOP_A_RESULT 8'h08
`define EHIOP_A_DRVSET 8'h0c
`define EHIOP_A_STATUS 8'h10
`define EHIOP_A_MASK 8'h14
`define EHIOP_A_STATE 8'h18
`define EHIOP_A_SETADDR 8'h1c
`define EHIOP_A_SETDATA 8'h20
`define EHIOP_A_SETWORD 8'h24

// command bits
`define EHIOP_CMD_START 0
`define EHIOP_CMD_AEND 1

// status and mask bits
`define EHIOP_ST_START 0
`define EHIOP_ST_ADONE 1
`define EHIOP_ST_MDONE 2
`define EHIOP_ST_BADSEL 3
`define EHIOP_ST_IGNORED 4

// reset values
`define EHIOP_CTRL_RST 3'h0
`define EHIOP_DRV_RST 12'h000
`define EHIOP_RES_RST 22'h000000
`define EHIOP_EV_RST 5'h00
`define EHIOP_JUDGE_IDLE 17'h1ffff

`endif

// ===== shared/ehiop_pkg.sv
// types of the handler port
`default_nettype none
package ehiop_pkg;

    // measurement sequence, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RESP = 4'h2,
        ST_ANALOG = 4'h4,
        ST_JUDGE = 4'h8
    } ehiop_state_e;

    // control register layout, bit 2 downward
    typedef struct packed {
        logic grade_mode;
        logic clear_on_start;
        logic ext_mode;
    } ehiop_ctrl_s;

    // result register layout; pri/sec one-hot: bit0 over, bit1 within, bit2 under
    typedef struct packed {
        logic [11:0] volt;
        logic [3:0] grade;
        logic [2:0] sec;
        logic [2:0] pri;
    } ehiop_result_s;

    // judgment pins, active low
    typedef struct packed {
        logic [13:0] cls_n;
        logic no_match_n;
        logic drv_err_n;
        logic sec_fail_n;
    } ehiop_judge_s;

endpackage : ehiop_pkg
`default_nettype wire

// ===== core/ehiop_setup_mem.sv
// stored setup memory, one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module ehiop_setup_mem (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [6:0] i_waddr,
    input wire logic [15:0] i_wdata,
    input wire logic [6:0] i_raddr,
    output logic [15:0] o_rdata
);
    logic [15:0] mem_ff [0:127];

    // array has no reset; contents are loaded by software before use
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    // read data from a register, so the word lags its address by one cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 16'h0000;
        end
        else
        begin
            o_rdata <= mem_ff[i_raddr];
        end
    end
endmodule : ehiop_setup_mem
`default_nettype wire

// ===== core/ehiop_ext_start_n_qual.sv
// start strobe qualifier: one pulse per low pulse of sufficient width
`timescale 1ns/1ns
`default_nettype none
module ehiop_ext_start_n_qual #(
    parameter int P_MIN_CYC = 10000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start_n,
    output logic o_fire
);
    localparam logic [15:0] L_LAST = 16'(P_MIN_CYC - 1);

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic fire_ff;
    logic nxt_fire;

    // count low cycles; saturate so a long pulse fires only once
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_fire = 1'b0;
        if (i_start_n)
        begin
            nxt_cnt = 16'h0000;
        end
        else if (cnt_ff < L_LAST)
        begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        else if (cnt_ff == L_LAST)
        begin
            nxt_cnt = cnt_ff + 16'h0001;
            nxt_fire = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= 16'h0000;
            fire_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            fire_ff <= nxt_fire;
        end
    end

    assign o_fire = fire_ff;
endmodule : ehiop_ext_start_n_qual
`default_nettype wire

// ===== core/ehiop_port.sv
// handler port of the measuring instrument: handshake, setup select, judgments
//
// Function
// - all port logic lines are active low
// - trigger low 100 us starts one measurement
// - triggers during analog measurement are ignored
// - trigger in external mode loads selected setup
// - selection used only when qualifier is asserted
// - primary over, within and under outputs
// - secondary over, within and under outputs
// - pass when judged parameters are within
// - fourteen class outputs plus no-match output
// - analog done strobe when analog part ends
// - measurement done strobe when judgment complete
// - drive error beyond ten percent deviation
// - judgments cleared at start or held
// - analog done deasserts 200 us after trigger
`timescale 1ns/1ns
`default_nettype none
`include "ehiop_defs.svh"
module ehiop_port #(
    parameter int P_EXT_START_N_MIN_CYC = `EHIOP_EXT_START_N_MIN_US * `EHIOP_CLK_MHZ,
    parameter int P_RESP_CYC = `EHIOP_RESP_US * `EHIOP_CLK_MHZ
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    output logic o_irq,
    input wire logic i_ext_start_n,
    input wire logic [6:0] i_setup_sel_bits_n,
    input wire logic i_setup_sel_qualify_n,
    output logic [13:0] o_grade_class_n,
    output logic o_no_grade_match_n,
    output logic o_analog_done_n,
    output logic o_meas_done_n,
    output logic o_drive_level_error_n,
    output logic o_secondary_fail_n
);
    // rest of the response time after the trigger has qualified
    localparam logic [15:0] L_WAIT_LAST = 16'(P_RESP_CYC - P_EXT_START_N_MIN_CYC - 1);

    ehiop_pkg::ehiop_state_e state_ff, nxt_state;
    ehiop_pkg::ehiop_ctrl_s ctrl_ff, nxt_ctrl;
    ehiop_pkg::ehiop_result_s res_ff, nxt_res;
    ehiop_pkg::ehiop_judge_s judge_ff, nxt_judge;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [11:0] drv_set_ff, nxt_drv_set;
    logic [6:0] act_num_ff, nxt_act_num;
    logic act_ok_ff, nxt_act_ok;
    logic [6:0] set_addr_ff, nxt_set_addr;
    logic adone_n_ff, nxt_adone_n;
    logic mdone_n_ff, nxt_mdone_n;
    logic [4:0] status_ff, nxt_status;
    logic [4:0] mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [4:0] ev;
    logic ext_start_n_fire;
    logic start_req;
    logic cmd_start;
    logic cmd_aend;
    logic mem_we;
    logic [15:0] set_word;
    logic [6:0] sel_num;

    // true when the level across the sample is off by more than a tenth
    function automatic logic f_drv_err(input logic [11:0] meas, input logic [11:0] set);
        logic [15:0] diff;
        diff = (meas >= set) ? {4'h0, meas - set} : {4'h0, set - meas};
        return 16'(diff * `EHIOP_DRV_TOL_DIV) > {4'h0, set};
    endfunction : f_drv_err

    // map a result onto the judgment pins for the selected mode
    function automatic ehiop_pkg::ehiop_judge_s f_judge(
        input ehiop_pkg::ehiop_result_s r,
        input ehiop_pkg::ehiop_ctrl_s c,
        input logic [11:0] set
    );
        ehiop_pkg::ehiop_judge_s j;
        logic p_judged;
        logic s_judged;
        logic pass;
        p_judged = |r.pri;
        s_judged = |r.sec;
        pass = (r.pri[1] & r.sec[1]) | (r.pri[1] & ~s_judged) | (r.sec[1] & ~p_judged);
        j = ehiop_pkg::ehiop_judge_s'(`EHIOP_JUDGE_IDLE);
        if (c.grade_mode)
        begin
            // class index 1..14; zero or fifteen means none matched
            if ((r.grade != 4'h0) && (r.grade != 4'hf))
            begin
                j.cls_n = ~14'(14'h0001 << (r.grade - 4'h1));
            end
            else
            begin
                j.no_match_n = 1'b0;
            end
        end
        else
        begin
            j.cls_n = ~{7'h00, pass, r.sec, r.pri};
        end
        j.drv_err_n = ~f_drv_err(r.volt, set);
        j.sec_fail_n = ~(s_judged & ~r.sec[1]);
        return j;
    endfunction : f_judge

    ehiop_ext_start_n_qual #(
        .P_MIN_CYC(P_EXT_START_N_MIN_CYC)
    ) u_ext_start_n (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start_n(i_ext_start_n),
        .o_fire(ext_start_n_fire)
    );

    // read address follows the active setup, so the word tracks it a cycle later
    ehiop_setup_mem u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(mem_we),
        .i_waddr(set_addr_ff),
        .i_wdata(i_wdata[15:0]),
        .i_raddr(act_num_ff),
        .o_rdata(set_word)
    );

    // command strobes and selected number from the pins
    assign cmd_start = i_we && (i_addr == `EHIOP_A_CMD) && i_wdata[`EHIOP_CMD_START];
    assign cmd_aend = i_we && (i_addr == `EHIOP_A_CMD) && i_wdata[`EHIOP_CMD_AEND];
    assign mem_we = i_we && (i_addr == `EHIOP_A_SETDATA);
    assign sel_num = ~i_setup_sel_bits_n;
    assign start_req = ctrl_ff.ext_mode ? ext_start_n_fire : cmd_start;

    // sequence, configuration, judgments, events and register reads
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ctrl = ctrl_ff;
        nxt_res = res_ff;
        nxt_judge = judge_ff;
        nxt_cnt = cnt_ff;
        nxt_drv_set = drv_set_ff;
        nxt_act_num = act_num_ff;
        nxt_act_ok = act_ok_ff;
        nxt_set_addr = set_addr_ff;
        nxt_adone_n = adone_n_ff;
        nxt_mdone_n = mdone_n_ff;
        nxt_mask = mask_ff;
        nxt_rdata = 32'h00000000;
        ev = `EHIOP_EV_RST;

        // plain register writes
        if (i_we)
        begin
            unique case (i_addr)
                `EHIOP_A_CTRL: nxt_ctrl = ehiop_pkg::ehiop_ctrl_s'(i_wdata[2:0]);
                `EHIOP_A_RESULT: nxt_res = ehiop_pkg::ehiop_result_s'(i_wdata[21:0]);
                `EHIOP_A_DRVSET: nxt_drv_set = i_wdata[11:0];
                `EHIOP_A_MASK: nxt_mask = i_wdata[4:0];
                `EHIOP_A_SETADDR: nxt_set_addr = i_wdata[6:0];
                default: nxt_mask = mask_ff;
            endcase
        end

        unique case (state_ff)
            ehiop_pkg::ST_IDLE:
            begin
                if (start_req)
                begin
                    nxt_state = ehiop_pkg::ST_RESP;
                    nxt_cnt = 16'h0000;
                    ev[`EHIOP_ST_START] = 1'b1;
                    if (ctrl_ff.clear_on_start)
                    begin
                        nxt_judge = ehiop_pkg::ehiop_judge_s'(`EHIOP_JUDGE_IDLE);
                    end
                    // pins name the setup only in external mode, and only when qualified
                    if (ctrl_ff.ext_mode && !i_setup_sel_qualify_n)
                    begin
                        if (sel_num <= `EHIOP_MAX_SETUP)
                        begin
                            nxt_act_num = sel_num;
                            nxt_act_ok = 1'b1;
                        end
                        else
                        begin
                            ev[`EHIOP_ST_BADSEL] = 1'b1;
                        end
                    end
                end
            end
            ehiop_pkg::ST_RESP:
            begin
                if (cnt_ff >= L_WAIT_LAST)
                begin
                    nxt_state = ehiop_pkg::ST_ANALOG;
                    nxt_adone_n = 1'b1;
                    nxt_mdone_n = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            ehiop_pkg::ST_ANALOG:
            begin
                if (cmd_aend)
                begin
                    nxt_state = ehiop_pkg::ST_JUDGE;
                    nxt_adone_n = 1'b0;
                    ev[`EHIOP_ST_ADONE] = 1'b1;
                end
            end
            ehiop_pkg::ST_JUDGE:
            begin
                // the result write itself ends the measurement
                if (i_we && (i_addr == `EHIOP_A_RESULT))
                begin
                    nxt_state = ehiop_pkg::ST_IDLE;
                    nxt_judge = f_judge(ehiop_pkg::ehiop_result_s'(i_wdata[21:0]),
                                        ctrl_ff, drv_set_ff);
                    nxt_mdone_n = 1'b0;
                    ev[`EHIOP_ST_MDONE] = 1'b1;
                end
            end
        endcase

        // a start while busy is dropped, but software is told
        if (start_req && (state_ff != ehiop_pkg::ST_IDLE))
        begin
            ev[`EHIOP_ST_IGNORED] = 1'b1;
        end

        // sticky events: a new event beats a clear in the same cycle
        nxt_status = status_ff;
        if (i_we && (i_addr == `EHIOP_A_STATUS))
        begin
            nxt_status = status_ff & ~i_wdata[4:0];
        end
        nxt_status = nxt_status | ev;
        nxt_irq = |(nxt_status & nxt_mask);

        // read data stand in the cycle after the strobe
        if (i_re)
        begin
            unique case (i_addr)
                `EHIOP_A_CTRL: nxt_rdata = {29'h00000000, ctrl_ff};
                `EHIOP_A_RESULT: nxt_rdata = {10'h000, res_ff};
                `EHIOP_A_DRVSET: nxt_rdata = {20'h00000, drv_set_ff};
                `EHIOP_A_STATUS: nxt_rdata = {27'h0000000, status_ff};
                `EHIOP_A_MASK: nxt_rdata = {27'h0000000, mask_ff};
                `EHIOP_A_STATE: nxt_rdata = {18'h00000, adone_n_ff, mdone_n_ff,
                                             act_ok_ff, act_num_ff, state_ff};
                `EHIOP_A_SETADDR: nxt_rdata = {25'h0000000, set_addr_ff};
                `EHIOP_A_SETWORD: nxt_rdata = {16'h0000, set_word};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= ehiop_pkg::ST_IDLE;
            ctrl_ff <= ehiop_pkg::ehiop_ctrl_s'(`EHIOP_CTRL_RST);
            res_ff <= ehiop_pkg::ehiop_result_s'(`EHIOP_RES_RST);
            judge_ff <= ehiop_pkg::ehiop_judge_s'(`EHIOP_JUDGE_IDLE);
            cnt_ff <= 16'h0000;
            drv_set_ff <= `EHIOP_DRV_RST;
            act_num_ff <= 7'h00;
            act_ok_ff <= 1'b0;
            set_addr_ff <= 7'h00;
            adone_n_ff <= 1'b0;
            mdone_n_ff <= 1'b0;
            status_ff <= `EHIOP_EV_RST;
            mask_ff <= `EHIOP_EV_RST;
            irq_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            res_ff <= nxt_res;
            judge_ff <= nxt_judge;
            cnt_ff <= nxt_cnt;
            drv_set_ff <= nxt_drv_set;
            act_num_ff <= nxt_act_num;
            act_ok_ff <= nxt_act_ok;
            set_addr_ff <= nxt_set_addr;
            adone_n_ff <= nxt_adone_n;
            mdone_n_ff <= nxt_mdone_n;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // pins straight from flops, low means asserted
    assign o_grade_class_n = judge_ff.cls_n;
    assign o_no_grade_match_n = judge_ff.no_match_n;
    assign o_drive_level_error_n = judge_ff.drv_err_n;
    assign o_secondary_fail_n = judge_ff.sec_fail_n;
    assign o_analog_done_n = adone_n_ff;
    assign o_meas_done_n = mdone_n_ff;
    assign o_irq = irq_ff;
    assign o_rdata = rdata_ff;
endmodule : ehiop_port
`default_nettype wire

// ===== bench/ehiop_port_assertions.sv
// pin and read port checks for the handler port
`timescale 1ns/1ns
`default_nettype none
module ehiop_port_chk #(
    parameter int P_EXT_START_N_MIN_CYC = 10000,
    parameter int P_RESP_CYC = 20000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_re,
    input wire logic [31:0] o_rdata,
    input wire logic [13:0] o_grade_class_n,
    input wire logic o_no_grade_match_n,
    input wire logic o_analog_done_n,
    input wire logic o_meas_done_n,
    input wire logic o_drive_level_error_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // both strobes leave idle together when the response time ends
    sequence analog_rise_s;
        $rose(o_analog_done_n);
    endsequence
    sequence meas_rise_s;
        $rose(o_meas_done_n);
    endsequence

    done_pair_a: assert property (analog_rise_s |-> meas_rise_s)
        else $error("done strobes left idle apart");
    done_order_a: assert property (!o_meas_done_n |-> !o_analog_done_n)
        else $error("meas done before analog done");
    // judgments only move at start or end, never mid-measurement
    judge_hold_a: assert property (o_meas_done_n && $past(o_meas_done_n)
        |-> $stable(o_grade_class_n) && $stable(o_drive_level_error_n))
        else $error("judgment moved mid-measurement");
    pri_onehot_a: assert property ($onehot0(~o_grade_class_n[2:0]))
        else $error("primary lines not exclusive");
    sec_onehot_a: assert property ($onehot0(~o_grade_class_n[5:3]))
        else $error("secondary lines not exclusive");
    no_match_a: assert property (!o_no_grade_match_n |-> &o_grade_class_n)
        else $error("no-match with a class line low");
    rdata_idle_a: assert property (!$past(i_re) |-> o_rdata == 32'h00000000)
        else $error("read data outside read slot");
    unmapped_read_a: assert property ($past(i_re) && $past(i_addr) > 8'h27
        |-> o_rdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule : ehiop_port_chk

bind ehiop_port ehiop_port_chk #(.P_EXT_START_N_MIN_CYC(P_EXT_START_N_MIN_CYC), .P_RESP_CYC(P_RESP_CYC)) chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_re(i_re), .o_rdata(o_rdata),
    .o_grade_class_n(o_grade_class_n), .o_no_grade_match_n(o_no_grade_match_n),
    .o_analog_done_n(o_analog_done_n), .o_meas_done_n(o_meas_done_n),
    .o_drive_level_error_n(o_drive_level_error_n)
);
`default_nettype wire

// ===== bench/ehiop_handler_model.sv
// handler model: trigger pulse and setup number on pulled-up lines
`timescale 1ns/1ns
`default_nettype none
module ehiop_handler_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    input wire logic [15:0] i_len,
    input wire logic [6:0] i_setup,
    input wire logic i_qual,
    input wire logic i_analog_done_n,
    output logic o_ext_start_n,
    output logic [6:0] o_setup_sel_bits_n,
    output logic o_setup_sel_qualify_n
);
    logic [15:0] cnt_ff;

    // released lines sit at the pull-up level, not at the last value
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= 16'h0000;
            o_ext_start_n <= 1'b1;
            o_setup_sel_bits_n <= 7'h7f;
            o_setup_sel_qualify_n <= 1'b1;
        end
        else if (i_go)
        begin
            cnt_ff <= i_len;
            o_ext_start_n <= 1'b0;
            o_setup_sel_bits_n <= ~i_setup;
            o_setup_sel_qualify_n <= ~i_qual;
        end
        else
        begin
            if (cnt_ff != 16'h0000)
                cnt_ff <= cnt_ff - 16'h0001;
            if (cnt_ff == 16'h0001)
                o_ext_start_n <= 1'b1;
            // setup is latched once the measurement runs, so let go
            if (i_analog_done_n && o_ext_start_n)
            begin
                o_setup_sel_bits_n <= 7'h7f;
                o_setup_sel_qualify_n <= 1'b1;
            end
        end
    end
endmodule : ehiop_handler_model
`default_nettype wire

// ===== bench/ehiop_port_tb_top.sv
// self-checking bench for the handler port
`timescale 1ns/1ns
`default_nettype none
`include "ehiop_defs.svh"
module ehiop_port_tb_top;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic go = 1'b0;
    logic qual = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [15:0] len = 16'h0004;
    logic [6:0] setup = 7'h00;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [13:0] cls_n;
    logic [6:0] sel_n;
    logic irq, start_n, qual_n, adone_n, mdone_n, drv_n, sfail_n, nomatch_n;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    // counts shortened so a measurement takes tens of cycles
    ehiop_port #(.P_EXT_START_N_MIN_CYC(4), .P_RESP_CYC(10)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_we(we),
        .i_re(re), .o_rdata(rdata), .o_irq(irq), .i_ext_start_n(start_n),
        .i_setup_sel_bits_n(sel_n), .i_setup_sel_qualify_n(qual_n), .o_grade_class_n(cls_n),
        .o_no_grade_match_n(nomatch_n), .o_analog_done_n(adone_n), .o_meas_done_n(mdone_n),
        .o_drive_level_error_n(drv_n), .o_secondary_fail_n(sfail_n)
    );

    ehiop_handler_model model_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_len(len), .i_setup(setup),
        .i_qual(qual), .i_analog_done_n(adone_n), .o_ext_start_n(start_n),
        .o_setup_sel_bits_n(sel_n), .o_setup_sel_qualify_n(qual_n)
    );

    // hang guard, far above the expected run length
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        we <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_clk);
        we <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        re <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic kick();
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
    endtask : kick

    // one measurement: start, wait response, analog end, result
    task automatic meas(input logic ext, input logic clr, input logic dbl,
        input logic [31:0] res, output int n);
        n = 0;
        if (ext)
            kick();
        else
            wr(`EHIOP_A_CMD, 32'h00000001);
        while (adone_n !== 1'b1 && n < 40)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("analog start", 1'b1, adone_n);
        if (clr)
            chk("cleared pins", 32'h00007fff, {nomatch_n, cls_n});
        if (dbl)
        begin
            kick();
            repeat (8) @(posedge i_clk);
            rd(`EHIOP_A_STATE);
            chk("state analog", 4'h4, d[3:0]);
            rd(`EHIOP_A_STATUS);
            chk("ignored flag", 1'b1, d[4]);
        end
        wr(`EHIOP_A_CMD, 32'h00000002);
        #1 chk("analog done", 1'b0, adone_n);
        wr(`EHIOP_A_RESULT, res);
        #1 chk("meas done", 1'b0, mdone_n);
    endtask : meas

    task automatic t_reset();
        chk("idle pins", 32'h0007fffc, {cls_n, nomatch_n, drv_n, sfail_n, adone_n, mdone_n});
        rd(`EHIOP_A_CTRL);
        chk("ctrl", 32'h00000000, d);
        rd(`EHIOP_A_STATUS);
        chk("status", 32'h00000000, d);
    endtask : t_reset

    task automatic t_ext();
        int n;
        wr(`EHIOP_A_SETADDR, 32'h00000063);
        wr(`EHIOP_A_SETDATA, 32'h00005a3c);
        wr(`EHIOP_A_DRVSET, 32'h00000064);
        wr(`EHIOP_A_CTRL, 32'h00000001);
        setup <= 7'h63;
        qual <= 1'b1;
        len <= 16'h0003;
        kick();
        repeat (20) @(posedge i_clk);
        #1 chk("short trigger", 1'b0, adone_n);
        len <= 16'h0004;
        meas(1'b1, 1'b0, 1'b1, 32'h0001b812, n);
        chk("response", 1'b1, n >= 10 && n <= 14);
        chk("pins within", 32'h00003fad, cls_n);
        chk("level ok", 1'b1, drv_n);
        rd(`EHIOP_A_STATE);
        chk("setup number", 7'h63, d[10:4]);
        rd(`EHIOP_A_SETWORD);
        chk("setup word", 32'h00005a3c, d);
        setup <= 7'h05;
        qual <= 1'b0;
        meas(1'b1, 1'b0, 1'b0, 32'h0001bc0c, n);
        chk("pins outside", 32'h00003ff3, cls_n);
        chk("level error", 1'b0, drv_n);
        chk("sec fail", 1'b0, sfail_n);
        rd(`EHIOP_A_STATE);
        chk("setup kept", 7'h63, d[10:4]);
        setup <= 7'h64;
        qual <= 1'b1;
        meas(1'b1, 1'b0, 1'b0, 32'h0001b812, n);
        rd(`EHIOP_A_STATE);
        chk("setup over max", 7'h63, d[10:4]);
        rd(`EHIOP_A_STATUS);
        chk("bad select flag", 1'b1, d[3]);
    endtask : t_ext

    task automatic t_grade();
        int n;
        logic [13:0] exp;
        wr(`EHIOP_A_CTRL, 32'h00000006);
        // index fifteen is the second code that matches no class
        for (int i = 0; i < 16; i++)
        begin
            exp = (i == 0 || i == 15) ? 14'h3fff : ~(14'h0001 << (i - 1));
            meas(1'b0, 1'b1, 1'b0, 32'h0001b800 | (i << 6), n);
            chk("class pins", exp, cls_n);
            chk("no match", i != 0 && i != 15, nomatch_n);
        end
        wr(`EHIOP_A_CTRL, 32'h00000000);
        meas(1'b0, 1'b0, 1'b0, 32'h0001b802, n);
        chk("one judged pass", 32'h00003fbd, cls_n);
    endtask : t_grade

    task automatic t_irq();
        chk("irq masked", 1'b0, irq);
        wr(`EHIOP_A_MASK, 32'h00000004);
        rd(`EHIOP_A_MASK);
        chk("mask", 32'h00000004, d);
        chk("irq raised", 1'b1, irq);
        wr(`EHIOP_A_STATUS, 32'h0000001f);
        rd(`EHIOP_A_STATUS);
        chk("status clear", 32'h00000000, d);
        chk("irq clear", 1'b0, irq);
        wr(8'h40, 32'hffffffff);
        rd(8'h40);
        chk("unmapped", 32'h00000000, d);
        rd(`EHIOP_A_CTRL);
        chk("ctrl kept", 32'h00000000, d);
    endtask : t_irq

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // reset two cycles, then the scenarios in turn
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_ext();
        t_grade();
        t_irq();
        tally_and_finish();
    end
endmodule : ehiop_port_tb_top
`default_nettype wire
